/* File: rtl/prf_top.v */
// Paged register file and program memory address decoder
`timescale 1ns/1ns
`include "prf_map.vh"

module prf_top (
    // Clock and reset
    input  wire        clk,
    input  wire        resetn,
    // Program memory decode
    input  wire        rom_large,
    input  wire [15:0] prog_addr,
    output wire        prog_valid,
    output wire        prog_vector,
    output wire [15:0] reset_pc,
    // Register bus from the core
    input  wire        reg_rd,
    input  wire        reg_wr,
    input  wire [1:0]  reg_mode,
    input  wire [7:0]  reg_addr,
    input  wire [7:0]  reg_wdata,
    output reg  [7:0]  reg_rdata,
    output reg         reg_rvalid,
    output reg         reg_err,
    // Bank select instructions and status
    input  wire        select_bank_zero_instr,
    input  wire        select_bank_one_instr,
    output wire        bank_sel,
    output wire [7:0]  page_select_pointer
);
    // Region codes of the register address space
    localparam [1:0] RGN_PRIME  = 2'h0;  // 00..bf, paged
    localparam [1:0] RGN_COMMON = 2'h1;  // c0..cf, set 1
    localparam [1:0] RGN_SYSTEM = 2'h2;  // d0..df, set 1
    localparam [1:0] RGN_BANKED = 2'h3;  // e0..ff, set 1 banks

    // Pointer, bank and read-side state
    reg  [7:0] page_ptr;
    reg        bank;
    reg        rd_paged;
    reg  [7:0] set1_q;
    reg  [7:0] rdata_hold;
    wire [7:0] paged_q;
    wire [7:0] rdata_fresh;

    // Set 1 storage: 0..31 unbanked, 32..63 bank 0, 64..95 bank 1
    reg  [7:0] set1_mem [0:95];

    // Address classification and strobes
    reg  [1:0] region;
    reg  [6:0] s1_idx;
    wire       upper;
    wire       indirect;
    wire       to_set1;
    wire       to_set2;
    wire       access;
    wire       bad_mode;
    wire       is_pp;
    wire       page;
    wire [8:0] p_addr;
    wire       p_we;
    wire       s1_we;
    wire       pp_we;

    // Program space decode; the vector area stays fetchable as code
    assign prog_valid  = prog_addr <= (rom_large ? `PRF_ROM32_TOP
                                                 : `PRF_ROM16_TOP);
    assign prog_vector = prog_addr <= `PRF_VECTOR_TOP;
    assign reset_pc    = `PRF_RESET_PC;

    // Status outputs straight from their flops
    assign page_select_pointer = page_ptr;
    assign bank_sel            = bank;

    // Region of the bus address, by its upper nibble
    always @* begin
        case (reg_addr[7:4])
            4'hc: begin
                region = RGN_COMMON;
            end
            4'hd: begin
                region = RGN_SYSTEM;
            end
            4'he, 4'hf: begin
                region = RGN_BANKED;
            end
            default: begin
                region = RGN_PRIME;
            end
        endcase
    end

    // Indirect and indexed modes reach set 2, register and working set 1
    assign upper    = reg_addr >= `PRF_SET1_BASE;
    assign indirect = (reg_mode == `PRF_MODE_INDIR) || (reg_mode == `PRF_MODE_INDEX);
    assign to_set2  = upper && indirect;
    assign to_set1  = upper && !indirect;
    assign access   = reg_rd || reg_wr;
    assign is_pp    = to_set1 && (reg_addr == `PRF_PAGE_PTR_ADDR);
    // Plain register mode into the common area is refused, not redirected
    assign bad_mode = to_set1 && (region == RGN_COMMON)
                      && (reg_mode == `PRF_MODE_REG);

    // Set 1 index; only the upper 32 bytes follow the bank select
    always @* begin
        s1_idx = 7'h00;
        case (region)
            RGN_COMMON, RGN_SYSTEM: begin
                s1_idx = {2'h0, reg_addr[4:0]};
            end
            RGN_BANKED: begin
                if (bank) begin
                    s1_idx = {2'h2, reg_addr[4:0]};
                end else begin
                    s1_idx = {2'h1, reg_addr[4:0]};
                end
            end
            default: begin
                s1_idx = 7'h00;
            end
        endcase
    end

    // Reads follow the source nibble, writes the destination nibble
    assign page   = reg_wr ? page_ptr[`PRF_DST_LSB] : page_ptr[`PRF_SRC_LSB];
    // 256 bytes a page, 00..bf prime and c0..ff set 2, 512 paged bytes
    assign p_addr = {page, reg_addr};
    // Strobes kept apart so a refused write cannot leak into storage
    assign p_we   = reg_wr && (!upper || to_set2);
    assign s1_we  = reg_wr && to_set1 && !is_pp && !bad_mode;
    assign pp_we  = reg_wr && is_pp;

    // Two pages of 256 bytes in one 512-byte store
    prf_ram #(.AW(9)) u_pages (
        .clk   (clk),
        .we    (p_we),
        .addr  (p_addr),
        .wdata (reg_wdata),
        .rdata (paged_q)
    );

    // Page pointer; written like any other set 1 register
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            page_ptr <= `PRF_PAGE_PTR_RST;
        end else if (pp_we) begin
            page_ptr <= reg_wdata;
        end
    end

    // Bank select; bank one wins if both instructions arrive together
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            bank <= 1'b0;
        end else if (select_bank_one_instr) begin
            bank <= 1'b1;
        end else if (select_bank_zero_instr) begin
            bank <= 1'b0;
        end
    end

    // Set 1 storage has no reset; software initialises what it uses
    always @(posedge clk) begin
        if (s1_we) begin
            set1_mem[s1_idx] <= reg_wdata;
        end
        if (is_pp) begin
            set1_q <= page_ptr;
        end else begin
            set1_q <= set1_mem[s1_idx];
        end
    end

    // Read handshake: answer valid one cycle after the request
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            reg_rvalid <= 1'b0;
            rd_paged   <= 1'b0;
            reg_err    <= 1'b0;
        end else begin
            reg_rvalid <= reg_rd;
            reg_err    <= access && bad_mode;
            // Source is latched per read, so idle cycles cannot swap it
            if (reg_rd) begin
                rd_paged <= !to_set1;
            end
        end
    end

    // Last answer, held so the data stays steady while the bus idles
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rdata_hold <= 8'h00;
        end else if (reg_rvalid) begin
            rdata_hold <= rdata_fresh;
        end
    end

    // Fresh data in the valid cycle, held data between reads
    assign rdata_fresh = rd_paged ? paged_q : set1_q;
    always @* begin
        if (reg_rvalid) begin
            reg_rdata = rdata_fresh;
        end else begin
            reg_rdata = rdata_hold;
        end
    end
endmodule

/* File: rtl/prf_map.vh */
// Address map, field positions and reset values of the paged register file
`ifndef PRF_MAP_VH
`define PRF_MAP_VH
`define PRF_ROM16_TOP      16'h3fff
`define PRF_ROM32_TOP      16'h7fff
`define PRF_VECTOR_TOP     16'h00ff
`define PRF_RESET_PC       16'h0100
`define PRF_PAGE_PTR_ADDR  8'hdf
`define PRF_PAGE_PTR_RST   8'h00
`define PRF_SET1_BASE      8'hc0
`define PRF_SYSREG_BASE    8'hd0
`define PRF_BANK_BASE      8'he0
`define PRF_SRC_LSB        0
`define PRF_DST_LSB        4
`define PRF_MODE_REG       2'd0
`define PRF_MODE_WORK      2'd1
`define PRF_MODE_INDIR     2'd2
`define PRF_MODE_INDEX     2'd3
`endif

/* File: rtl/prf_ram.v */
// Single-port byte RAM with synchronous read, used for paged storage
`timescale 1ns/1ns
module prf_ram #(
    parameter AW = 9
) (
    input  wire          clk,
    input  wire          we,
    input  wire [AW-1:0] addr,
    input  wire [7:0]    wdata,
    output reg  [7:0]    rdata
);
    reg [7:0] mem [0:(1<<AW)-1];

    // Read-before-write, registered data output
    always @(posedge clk) begin
        if (we) begin
            mem[addr] <= wdata;
        end
        rdata <= mem[addr];
    end
endmodule

/* File: testbench/prf_chk.sv */
// Port assertions for the paged register file
`timescale 1ns/1ns
module prf_chk (
    input wire clk, resetn, rom_large, prog_valid, prog_vector, reg_rd, reg_wr,
    input wire reg_rvalid, reg_err, select_bank_one_instr, bank_sel,
    input wire [15:0] prog_addr, reset_pc,
    input wire [1:0] reg_mode,
    input wire [7:0] reg_addr, reg_wdata, page_select_pointer
);
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    chk_rd_answer: assert property (reg_rd |=> reg_rvalid) else $error("no answer");
    chk_no_stray: assert property (!reg_rd |=> !reg_rvalid) else $error("stray");
    chk_prog_ok: assert property (
        prog_valid == !(prog_addr[15] || !rom_large && prog_addr[14])) else $error("range");
    chk_vec_zone: assert property (
        prog_vector == (prog_addr < 16'h0100)) else $error("vector");
    chk_start_pc: assert property (reset_pc == 16'h0100) else $error("start");
    chk_err_common: assert property (
        (reg_rd || reg_wr) && reg_mode == 2'd0 && reg_addr[7:4] == 4'hc |=> reg_err)
        else $error("no refusal");
    chk_bank_one: assert property (
        select_bank_one_instr |=> bank_sel) else $error("bank");
    chk_page_wr: assert property (
        reg_wr && reg_mode == 2'd0 && reg_addr == 8'hdf |=> page_select_pointer == $past(reg_wdata))
        else $error("page");
    cover property (reg_err);
    cover property (bank_sel ##1 !bank_sel);
    cover property (reg_rvalid && page_select_pointer == 8'h10);
endmodule
bind prf_top prf_chk chk_u (.*);

/* File: testbench/prf_cpu.sv */
// CPU core model driving the register bus
`timescale 1ns/1ns
module prf_cpu (
    input  wire       clk,
    output reg        reg_rd = 0,
    output reg        reg_wr = 0,
    output reg  [1:0] reg_mode = 0,
    output reg  [7:0] reg_addr = 0,
    output reg  [7:0] reg_wdata = 0
);
    // One-cycle strobe; callers use working mode for the common area, register mode only to provoke reg_err
    task acc(input logic w, input logic [1:0] m, input logic [7:0] a, d);
        @(posedge clk);
        {reg_rd, reg_wr, reg_mode, reg_addr, reg_wdata} <= {!w, w, m, a, d};
        @(posedge clk);
        // Idle bus shows inverted values so stale data cannot pass
        {reg_rd, reg_wr, reg_addr, reg_wdata} <= {2'b00, ~a, ~d};
    endtask
endmodule

/* File: testbench/tb_prf_top.sv */
// Self-checking bench for the paged register file
`timescale 1ns/1ns
module tb_prf_top;
    logic clk = 0, resetn = 0, rom_large = 0;
    logic select_bank_zero_instr = 0, select_bank_one_instr = 0;
    logic [15:0] prog_addr = 0;
    logic [15:0] tab [6] = '{16'h00ff, 16'h0100, 16'h3fff, 16'h4000, 16'h7fff, 16'h8000};
    wire reg_rd, reg_wr, prog_valid, prog_vector, reg_rvalid, reg_err, bank_sel;
    wire [1:0] reg_mode;
    wire [7:0] reg_addr, reg_wdata, reg_rdata, page_select_pointer;
    wire [15:0] reset_pc;
    int fails = 0, checks = 0;
    always #10 clk = ~clk;
    prf_cpu cpu_u (.*);
    prf_top dut_u (.*);
    task cmp(input logic [15:0] got, exp);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %0t got %h want %h", $time, got, exp);
        end
    endtask
    task rdv(input logic [1:0] m, input logic [7:0] a, exp);
        cpu_u.acc(0, m, a, 8'h00);
        #1 cmp({reg_rvalid, reg_rdata}, {1'b1, exp});
        // Valid drops after one cycle while the byte stays put
        @(posedge clk);
        #1 cmp({reg_rvalid, reg_rdata}, {1'b0, exp});
    endtask
    task bank_sw(input logic one);
        @(posedge clk);
        {select_bank_zero_instr, select_bank_one_instr} <= {!one, one};
        @(posedge clk);
        {select_bank_zero_instr, select_bank_one_instr} <= 2'b00;
    endtask
    task print_verdict;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task t_reset;
        cmp(page_select_pointer, 8'h00);
        cmp(bank_sel, 1'b0);
        cmp(reset_pc, 16'h0100);
        $display("reset test done");
    endtask
    task t_prog;
        foreach (tab[i]) for (int r = 0; r < 2; r++) begin
            @(posedge clk);
            rom_large <= r[0];
            prog_addr <= tab[i];
            #1 cmp(prog_valid, tab[i] <= (r ? 16'h7fff : 16'h3fff));
            cmp(prog_vector, tab[i] <= 16'h00ff);
        end
        $display("program map test done");
    endtask
    // Pages differ only by pointer nibbles, so each page gets its own pattern
    task t_page;
        cpu_u.acc(1, 0, 8'hdf, 8'h10);
        cpu_u.acc(1, 2, 8'h40, 8'ha5);
        cpu_u.acc(1, 0, 8'hdf, 8'h00);
        cpu_u.acc(1, 3, 8'h40, 8'h3c);
        cpu_u.acc(1, 0, 8'hdf, 8'h01);
        rdv(1, 8'h40, 8'ha5);
        cpu_u.acc(1, 0, 8'hdf, 8'h10);
        rdv(0, 8'h40, 8'h3c);
        rdv(0, 8'hdf, 8'h10);
        $display("page test done");
    endtask
    task t_set;
        cpu_u.acc(1, 0, 8'hdf, 8'h00);
        cpu_u.acc(1, 1, 8'hc5, 8'h5a);
        cpu_u.acc(1, 2, 8'hc5, 8'hc3);
        cpu_u.acc(1, 0, 8'hc5, 8'hff);
        #1 cmp(reg_err, 1'b1);
        rdv(1, 8'hc5, 8'h5a);
        rdv(3, 8'hc5, 8'hc3);
        cpu_u.acc(1, 0, 8'hbf, 8'h96);
        rdv(2, 8'hbf, 8'h96);
        cpu_u.acc(1, 0, 8'hdf, 8'h11);
        rdv(1, 8'hc5, 8'h5a);
        $display("set test done");
    endtask
    task t_bank;
        bank_sw(1);
        cpu_u.acc(1, 0, 8'he0, 8'h11);
        cpu_u.acc(1, 0, 8'hd3, 8'h77);
        bank_sw(0);
        cpu_u.acc(1, 0, 8'he0, 8'h22);
        #1 cmp(bank_sel, 1'b0);
        rdv(0, 8'hd3, 8'h77);
        bank_sw(1);
        rdv(0, 8'he0, 8'h11);
        $display("bank test done");
    endtask
    // Reset in mid-run with bank one and both pages set
    task t_rerun;
        cmp(page_select_pointer, 8'h11);
        cmp(bank_sel, 1'b1);
        @(posedge clk);
        resetn <= 0;
        @(posedge clk);
        #1 cmp(page_select_pointer, 8'h00);
        cmp(bank_sel, 1'b0);
        cmp({reg_rvalid, reg_err}, 2'b00);
        @(posedge clk);
        resetn <= 1;
        rdv(0, 8'he0, 8'h22);
        $display("mid-run reset test done");
    endtask
    initial begin
        repeat (6) @(posedge clk);
        resetn <= 1;
        t_reset;
        t_prog;
        t_page;
        t_set;
        t_bank;
        t_rerun;
        print_verdict;
    end
    // Whole run needs well under 200 cycles
    initial begin
        #20000;
        fails++;
        print_verdict;
    end
endmodule
